// [hw/error_byte_counter.sv]
/*
  checker error byte counter: running count, lock-and-clear snapshot.
  assumes error pulses come from logic on clk.
*/
`timescale 1ns/1ps
`include "phy_regs_map.svh"
module error_byte_counter
  import phy_regs_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // events
  input  wire logic                  error_byte,
  input  wire logic                  wrap_mode,
  input  wire logic                  lock_clear,
  // result
  output phy_regs_pkg::count_type    locked_count
);
  import phy_regs_pkg::*;

  typedef struct packed {
    count_type run;
    count_type locked;
  } state_type;

  state_type state_reg;
  state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (error_byte) begin
      if (wrap_mode || state_reg.run != `ERROR_COUNT_MAX) begin
        state_next.run = state_reg.run + 8'h01;
      end
    end
    if (lock_clear) begin
      state_next.locked = state_reg.run;
      state_next.run    = error_byte ? 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign locked_count = state_reg.locked;
endmodule : error_byte_counter

// [hw/phy_regs_map.svh]
/*
  offsets, field positions and reset values of the 10 Mb/s and self test register bank.
  assumes nothing; definitions only.
*/
`ifndef PHY_REGS_MAP_SVH
`define PHY_REGS_MAP_SVH

`define TEN_MBIT_CONTROL_STATUS_INDEX 8'h1a
`define SELF_TEST_ERROR_AND_GAP_INDEX 8'h1b
`define SELF_TEST_PACKET_SIZE_INDEX   8'h1c

`define TEN_MBIT_CONTROL_STATUS_RESET 16'h0000
`define SELF_TEST_ERROR_AND_GAP_RESET 16'h007d
`define SELF_TEST_PACKET_SIZE_RESET   16'h05ee

`define LOW_THRESHOLD_BIT   13
`define SQUELCH_MSB         12
`define SQUELCH_LSB         9
`define LINK_PULSE_BIT      7
`define POLARITY_BIT        4
`define JABBER_OFF_BIT      0
`define LOCK_CLEAR_BIT      15
`define ERROR_COUNT_MSB     15
`define ERROR_COUNT_LSB     8
`define GAP_MSB             7
`define GAP_LSB             0
`define PACKET_SIZE_MSB     10
`define PACKET_SIZE_LSB     0

`define SQUELCH_MAX_CODE    4'h8
`define ERROR_COUNT_MAX     8'hff
`define GAP_BYTES_SHIFT     2

`endif

// [hw/phy_regs_pkg.sv]
/*
  types shared by the register bank and its helper modules.
  assumes the map header for numeric constants.
*/
package phy_regs_pkg;
  typedef logic [15:0] reg_word_type;
  typedef logic [7:0]  count_type;
  typedef logic [10:0] size_type;
  typedef logic [9:0]  gap_bytes_type;
  typedef logic [3:0]  squelch_type;
endpackage : phy_regs_pkg

// [hw/pin_sync.sv]
/*
  three flop synchroniser with agreement filter for one pin level.
  assumes input is asynchronous to clk.
*/
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // level
  input  wire logic pin_async,
  output logic      pin_level
);
  typedef struct packed {
    logic [2:0] stages;
    logic       level;
  } state_type;

  state_type state_reg;
  state_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stages = {state_reg.stages[1:0], pin_async};
    if (state_reg.stages[1] == state_reg.stages[2]) begin
      state_next.level = state_reg.stages[2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_level = state_reg.level;
endmodule : pin_sync

// [hw/ten_mbit_bist_regs.sv]
/*
  apb register bank: 10 Mb/s receive and transmit options, polarity status, self test settings.
  assumes error byte pulses on clk; inverted polarity is a level from the receiver pin, asynchronous to clk.
*/
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "phy_regs_map.svh"
module ten_mbit_bist_regs
  import phy_regs_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [9:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // receiver and checker events
  input  wire logic                  polarity_inverted_pin,
  input  wire logic                  phy_status_read,
  input  wire logic                  error_byte,
  input  wire logic                  error_wrap_mode,
  input  wire logic                  ten_mbit_mode,
  // status register mirror
  output logic                       phy_status_polarity,
  // settings to receiver, transmitter and generator
  output logic                       low_threshold_enable,
  output phy_regs_pkg::squelch_type  squelch_level,
  output logic                       link_pulse_suppress,
  output logic                       jabber_enable,
  output phy_regs_pkg::gap_bytes_type test_packet_gap,
  output phy_regs_pkg::size_type     test_packet_size
);
  import phy_regs_pkg::*;

  typedef struct packed {
    logic        low_threshold;
    squelch_type squelch;
    logic        link_pulse_off;
    logic        jabber_off;
    logic        jabber_on;
    logic        polarity;
    logic        pol_seen;
    count_type   gap;
    size_type    size;
    logic [31:0] rdata;
  } state_type;

  state_type    state_reg;
  state_type    state_next;
  logic         pol_level;
  logic         access_cycle;
  logic         hit_ctrl;
  logic         hit_err;
  logic         hit_size;
  logic         lock_clear;
  count_type    locked_count;
  reg_word_type ctrl_word;
  reg_word_type err_word;
  reg_word_type size_word;

  pin_sync u_pol_sync (
    .clk       (clk),
    .srst      (srst),
    .pin_async (polarity_inverted_pin),
    .pin_level (pol_level)
  );

  assign access_cycle = psel && !penable;
  assign hit_ctrl = paddr == {`TEN_MBIT_CONTROL_STATUS_INDEX, 2'b00};
  assign hit_err  = paddr == {`SELF_TEST_ERROR_AND_GAP_INDEX, 2'b00};
  assign hit_size = paddr == {`SELF_TEST_PACKET_SIZE_INDEX, 2'b00};
  assign lock_clear = psel && penable && pwrite && hit_err && pwdata[`LOCK_CLEAR_BIT];

  error_byte_counter u_counter (
    .clk          (clk),
    .srst         (srst),
    .error_byte   (error_byte),
    .wrap_mode    (error_wrap_mode),
    .lock_clear   (lock_clear),
    .locked_count (locked_count)
  );

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[`LOW_THRESHOLD_BIT]        = state_reg.low_threshold;
    ctrl_word[`SQUELCH_MSB:`SQUELCH_LSB] = state_reg.squelch;
    ctrl_word[`LINK_PULSE_BIT]           = state_reg.link_pulse_off;
    ctrl_word[`POLARITY_BIT]             = state_reg.polarity;
    ctrl_word[`JABBER_OFF_BIT]           = state_reg.jabber_off;
    err_word = 16'h0000;
    err_word[`ERROR_COUNT_MSB:`ERROR_COUNT_LSB] = locked_count;
    err_word[`GAP_MSB:`GAP_LSB]                 = state_reg.gap;
    size_word = 16'h0000;
    size_word[`PACKET_SIZE_MSB:`PACKET_SIZE_LSB] = state_reg.size;
  end

  always_comb begin
    state_next = state_reg;
    state_next.pol_seen = pol_level;
    // read clears polarity; a new detection in that cycle wins
    if (access_cycle && !pwrite && hit_ctrl) begin
      state_next.polarity = 1'b0;
    end
    if (pol_level && !state_reg.pol_seen) begin
      state_next.polarity = 1'b1;
    end
    if (access_cycle) begin
      state_next.rdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_ctrl) begin
          state_next.rdata = {16'h0000, ctrl_word};
        end else if (hit_err) begin
          state_next.rdata = {16'h0000, err_word};
        end else if (hit_size) begin
          state_next.rdata = {16'h0000, size_word};
        end
      end
    end
    if (psel && penable && pwrite) begin
      if (hit_ctrl) begin
        state_next.low_threshold  = pwdata[`LOW_THRESHOLD_BIT];
        state_next.squelch        = pwdata[`SQUELCH_MSB:`SQUELCH_LSB];
        state_next.link_pulse_off = pwdata[`LINK_PULSE_BIT];
        state_next.jabber_off     = pwdata[`JABBER_OFF_BIT];
      end
      if (hit_err) begin
        state_next.gap = pwdata[`GAP_MSB:`GAP_LSB];
      end
      if (hit_size) begin
        state_next.size = pwdata[`PACKET_SIZE_MSB:`PACKET_SIZE_LSB];
      end
    end
    // jabber override only bites while running 10 Mb/s
    state_next.jabber_on = !(state_next.jabber_off && ten_mbit_mode);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg               <= '0;
      state_reg.low_threshold <= 1'b0;
      state_reg.jabber_on     <= 1'b1;
      state_reg.gap           <= 8'(`SELF_TEST_ERROR_AND_GAP_RESET);
      state_reg.size          <= 11'(`SELF_TEST_PACKET_SIZE_RESET);
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata  = state_reg.rdata;
  assign pready  = psel && penable;
  assign pslverr = 1'b0;
  // status-register read leaves the flag alone
  assign phy_status_polarity  = state_reg.polarity;
  assign low_threshold_enable = state_reg.low_threshold;
  assign squelch_level        = state_reg.squelch;
  assign link_pulse_suppress  = state_reg.link_pulse_off;
  assign jabber_enable        = state_reg.jabber_on;
  assign test_packet_gap      = {2'b00, state_reg.gap} << `GAP_BYTES_SHIFT;
  assign test_packet_size     = state_reg.size;
endmodule : ten_mbit_bist_regs

// [test/ten_mbit_bist_regs_asserts.sv]
/* port assertions for the register bank.
   assumes a zero wait state apb slave on clk. */
`timescale 1ns/1ps
module ten_mbit_bist_regs_asserts
  import phy_regs_pkg::*;
(
  // clock, reset and apb
  input wire logic clk, srst, psel, penable, pwrite, pready, pslverr,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // settings
  input wire logic ten_mbit_mode, low_threshold_enable, link_pulse_suppress, jabber_enable,
  input phy_regs_pkg::squelch_type squelch_level,
  input phy_regs_pkg::gap_bytes_type test_packet_gap,
  input phy_regs_pkg::size_type test_packet_size
);
  import phy_regs_pkg::*;
  wire acc = psel & penable;
  wire wr  = acc & pwrite;
  wire su  = psel & !penable & !pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_ready; acc |-> pready && !pslverr; endproperty
  property p_ctl; wr && paddr == 10'h068 |=> low_threshold_enable == $past(pwdata[13])
    && link_pulse_suppress == $past(pwdata[7]); endproperty
  property p_sq; wr && paddr == 10'h068 |=> squelch_level == $past(pwdata[12:9]); endproperty
  property p_jab; !ten_mbit_mode |=> jabber_enable; endproperty
  property p_gap; wr && paddr == 10'h06c |=> test_packet_gap == {$past(pwdata[7:0]), 2'b00}; endproperty
  property p_size; wr && paddr == 10'h070 |=> test_packet_size == $past(pwdata[10:0]); endproperty
  property p_rdsz; su && paddr == 10'h070 |=> prdata == {21'h0, test_packet_size}; endproperty
  property p_resv; su && paddr == 10'h068 |=> (prdata & 32'hffff_c16e) == 0; endproperty
  a_ready: assert property (p_ready) else $error("bad pready");
  a_ctl: assert property (p_ctl) else $error("bad control bits");
  a_sq: assert property (p_sq) else $error("bad squelch");
  a_jab: assert property (p_jab) else $error("bad jabber");
  a_gap: assert property (p_gap) else $error("bad gap");
  a_size: assert property (p_size) else $error("bad size");
  a_rdsz: assert property (p_rdsz) else $error("bad size read");
  a_resv: assert property (p_resv) else $error("reserved set");
  c_wr: cover property (wr);
  c_rd: cover property (su && paddr == 10'h068);
  c_jab: cover property (ten_mbit_mode && !jabber_enable);
endmodule : ten_mbit_bist_regs_asserts

bind ten_mbit_bist_regs ten_mbit_bist_regs_asserts i_chk (.clk, .srst, .psel, .penable, .pwrite, .pready,
  .pslverr, .paddr, .pwdata, .prdata, .ten_mbit_mode, .low_threshold_enable, .link_pulse_suppress,
  .jabber_enable, .squelch_level, .test_packet_gap, .test_packet_size);

// [test/ten_mbit_bist_regs_tb.sv]
/* self-checking bench for the register bank.
   assumes zero wait state apb and a 40 MHz clock. */
`timescale 1ns/1ps
module ten_mbit_bist_regs_tb;
  import phy_regs_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic pin = 0, phy_status_read = 0, error_byte = 0, wrap = 0, ten_mbit_mode = 0;
  logic phy_status_polarity, low_threshold_enable, link_pulse_suppress, jabber_enable;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  squelch_type squelch_level;
  gap_bytes_type test_packet_gap;
  size_type test_packet_size;
  int bad_count = 0, checks = 0, cyc = 0, d, gap = 'h7d, cnt = 0, run = 0;

  ten_mbit_bist_regs i_dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .polarity_inverted_pin(pin), .phy_status_read, .error_byte, .error_wrap_mode(wrap),
    .ten_mbit_mode, .phy_status_polarity, .low_threshold_enable, .squelch_level, .link_pulse_suppress,
    .jabber_enable, .test_packet_gap, .test_packet_size);

  initial forever #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] v);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb

  // counter model: saturate or wrap, lock then read back
  task automatic err_phase(input int n, input logic w);
    wrap <= w;
    repeat (n) begin
      error_byte <= 1;
      @(posedge clk);
      error_byte <= 0;
      @(posedge clk);
      run++;
      if (run > 255) run = w ? 0 : 255;
    end
    apb(1, 'h6c, 'h8000 | gap);
    cnt = run;
    run = 0;
    apb(0, 'h6c, 0);
    chk("err_reg", rd, cnt << 8 | gap);
  endtask : err_phase

  initial begin
    d = $urandom(51);
    repeat (10) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    apb(0, 'h68, 0);
    chk("ctrl", rd, 0);
    apb(0, 'h6c, 0);
    chk("gap_reg", rd, 'h7d);
    apb(0, 'h70, 0);
    chk("size_reg", rd, 'h5ee);
    chk("gap_out", test_packet_gap, 500);
    apb(1, 'h74, '1);
    apb(0, 'h74, 0);
    chk("unmapped", rd, 0);
    for (int c = 0; c <= 8; c++) begin
      d = ($urandom & 'hffff_e1ff) | (c << 9);
      ten_mbit_mode <= 1'($urandom);
      apb(1, 'h68, d);
      apb(0, 'h68, 0);
      chk("ctrl", rd, d & 'h3e81);
      chk("squelch", squelch_level, c);
      chk("nlp", link_pulse_suppress, d[7]);
      chk("thr", low_threshold_enable, d[13]);
      chk("jab", jabber_enable, !(d[0] && ten_mbit_mode));
    end
    repeat (4) begin
      d = $urandom & 'h7fff;
      gap = d & 'hff;
      apb(1, 'h6c, d);
      apb(0, 'h6c, 0);
      chk("gap_reg", rd, gap);
      chk("gap_out", test_packet_gap, gap * 4);
      apb(1, 'h70, d);
      apb(0, 'h70, 0);
      chk("size_reg", rd, d & 'h7ff);
      chk("size_out", test_packet_size, d & 'h7ff);
    end
    pin <= 1;
    repeat (12) @(posedge clk);
    phy_status_read <= 1;
    @(posedge clk);
    phy_status_read <= 0;
    @(posedge clk);
    chk("pol", phy_status_polarity, 1);
    apb(0, 'h68, 0);
    chk("pol_bit", rd[4], 1);
    chk("pol_clr", phy_status_polarity, 0);
    apb(0, 'h68, 0);
    chk("pol_bit", rd[4], 0);
    pin <= 0;
    err_phase(5, 0);
    err_phase(300, 0);
    err_phase(260, 1);
    wrap_up();
  end
endmodule : ten_mbit_bist_regs_tb
